// file: sim/drs_analog_model.sv
`timescale 1ns/1ps
module drs_analog_model #(
    parameter RISE = 8
) (
    input wire clock,
    input wire [1:0] drive,
    output wire [1:0] near_reg,
    output wire [1:0] discharged
);
    reg [3:0] lvl [0:1];
    integer i;
    initial begin
        lvl[0] = 4'h0;
        lvl[1] = 4'h0;
    end
    // Output climbs while driven, decays to ground once released
    always @(posedge clock) begin
        for (i = 0; i < 2; i = i + 1)
            if (drive[i] && lvl[i] != RISE) lvl[i] <= lvl[i] + 4'h1;
            else if (!drive[i] && lvl[i] != 4'h0) lvl[i] <= lvl[i] - 4'h1;
    end
    assign near_reg = {lvl[1] == RISE, lvl[0] == RISE};
    assign discharged = {lvl[1] == 4'h0, lvl[0] == 4'h0};
endmodule // drs_analog_model

// file: sim/drs_seq_checker.sv
`timescale 1ns/1ps
module drs_seq_checker #(
    parameter STARTUP_CYC = 20
) (
    input wire clock,
    input wire nrst,
    input wire shutdown_input_n,
    input wire pos_near_reg,
    input wire neg_near_reg,
    input wire pos_discharged,
    input wire neg_discharged,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [3:0] avs_byteenable,
    input wire [31:0] avs_writedata,
    input wire avs_waitrequest,
    input wire pos_ramp_discharge,
    input wire neg_ramp_discharge,
    input wire pos_ramp_charge,
    input wire neg_ramp_charge,
    input wire [3:0] ramp_current_ua,
    input wire pos_switch_en,
    input wire neg_switch_en,
    input wire disconnect_on,
    input wire out_discharge_en,
    input wire powered,
    input wire seq_done
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // Cycles since the last command write or shutdown
    reg [15:0] since_cmd;
    wire cmd_wr = avs_write && !avs_waitrequest && avs_address == 4'hC;
    always @(posedge clock or negedge nrst)
        if (!nrst) since_cmd <= 16'h0000;
        else if (cmd_wr || !shutdown_input_n) since_cmd <= 16'h0000;
        else if (since_cmd != 16'hFFFF) since_cmd <= since_cmd + 16'h0001;
    a_ramps_held: assert property (!powered [*2] |->
        pos_ramp_discharge && neg_ramp_discharge) else $error("ramp not held");
    a_current_pow2: assert property ($onehot(ramp_current_ua))
        else $error("ramp current not a power of two");
    a_startup_wait: assert property (
        $rose(pos_ramp_charge) || $rose(neg_ramp_charge) |->
        since_cmd >= STARTUP_CYC - 2) else $error("startup delay short");
    a_pos_second: assert property (
        $rose(pos_ramp_charge) && $past(neg_ramp_charge) |->
        $past(neg_near_reg)) else $error("positive ramp too early");
    a_neg_second: assert property (
        $rose(neg_ramp_charge) && $past(pos_ramp_charge) |->
        $past(pos_near_reg)) else $error("negative ramp too early");
    a_done_both: assert property ($rose(seq_done) |->
        $past(pos_near_reg) && $past(neg_near_reg)) else $error("early done");
    a_pd_off: assert property (out_discharge_en |->
        !pos_switch_en && !neg_switch_en)
        else $error("switch on in discharge");
    a_pd_wait: assert property (
        out_discharge_en && !(pos_discharged && neg_discharged) |=> powered)
        else $error("powered down before discharge");
    a_switches_off_cmd_stop: assert property (
        cmd_wr && avs_byteenable[0] && avs_writedata[4] && shutdown_input_n
        |-> ##[1:2] !pos_switch_en && !neg_switch_en && !disconnect_on)
        else $error("switches not off");
    a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("wait too long");
    c_done: cover property ($rose(seq_done));
    c_discharge: cover property ($rose(out_discharge_en));
    c_together: cover property ($rose(pos_ramp_charge) &&
        $rose(neg_ramp_charge));
endmodule // drs_seq_checker

bind drs_sequencer drs_seq_checker #(.STARTUP_CYC(STARTUP_CYC)) u_chk (
    .clock(clock), .nrst(nrst), .shutdown_input_n(shutdown_input_n),
    .pos_near_reg(pos_near_reg), .neg_near_reg(neg_near_reg),
    .pos_discharged(pos_discharged), .neg_discharged(neg_discharged),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_waitrequest(avs_waitrequest), .pos_ramp_charge(pos_ramp_charge),
    .pos_ramp_discharge(pos_ramp_discharge), .neg_ramp_charge(neg_ramp_charge),
    .neg_ramp_discharge(neg_ramp_discharge), .ramp_current_ua(ramp_current_ua),
    .pos_switch_en(pos_switch_en), .neg_switch_en(neg_switch_en),
    .disconnect_on(disconnect_on), .out_discharge_en(out_discharge_en),
    .powered(powered), .seq_done(seq_done));

// file: sim/drs_sequencer_tb_top.sv
`timescale 1ns/1ps
module drs_sequencer_tb_top;
    localparam STC = 20;
    reg clock = 1'b0, nrst = 1'b0, shutdown_input_n = 1'b1, vpp_ok = 1'b1;
    reg [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
    reg avs_read = 1'b0, avs_write = 1'b0;
    reg [31:0] avs_writedata = 32'h00000000;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, pos_near_reg, neg_near_reg, pos_discharged;
    wire neg_discharged, pos_ramp_discharge, neg_ramp_discharge, powered;
    wire pos_ramp_charge, neg_ramp_charge, pos_switch_en, neg_switch_en;
    wire disconnect_on, out_discharge_en, seq_done;
    wire [3:0] ramp_current_ua;
    wire [1:0] avs_response;
    wire [7:0] cfg_pos_code, cfg_neg_code;
    wire cfg_pos_fine;
    logic [31:0] q;
    integer err_count = 0, checks_done = 0;
    always #5 clock = ~clock;
    drs_sequencer #(.STARTUP_CYC(STC)) dut (.clock(clock), .nrst(nrst),
        .shutdown_input_n(shutdown_input_n), .vpp_ok(vpp_ok),
        .pos_near_reg(pos_near_reg), .neg_near_reg(neg_near_reg),
        .pos_discharged(pos_discharged), .neg_discharged(neg_discharged),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .avs_response(avs_response), .pos_ramp_discharge(pos_ramp_discharge),
        .neg_ramp_discharge(neg_ramp_discharge), .powered(powered),
        .pos_ramp_charge(pos_ramp_charge), .neg_ramp_charge(neg_ramp_charge),
        .ramp_current_ua(ramp_current_ua), .pos_switch_en(pos_switch_en),
        .neg_switch_en(neg_switch_en), .disconnect_on(disconnect_on),
        .out_discharge_en(out_discharge_en), .seq_done(seq_done),
        .cfg_pos_code(cfg_pos_code), .cfg_neg_code(cfg_neg_code),
        .cfg_pos_fine(cfg_pos_fine));
    drs_analog_model u_analog (.clock(clock),
        .drive({neg_switch_en | neg_ramp_charge,
            pos_switch_en | pos_ramp_charge}),
        .near_reg({neg_near_reg, pos_near_reg}),
        .discharged({neg_discharged, pos_discharged}));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", checks_done, err_count);
            if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
            else $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    task bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        integer n;
        begin
            avs_address <= a;
            avs_writedata <= {24'h000000, d};
            avs_write <= wr;
            avs_read <= ~wr;
            n = 0;
            @(posedge clock);
            while (avs_waitrequest !== 1'b0) begin
                n = n + 1;
                if (n > 20) begin
                    chk(32'h0, 32'h1);
                    finish_test;
                end
                @(posedge clock);
            end
            q = avs_readdata;
            avs_write <= 1'b0;
            avs_read <= 1'b0;
            @(posedge clock);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task rd(input logic [3:0] a, input logic [7:0] e);
        begin
            bus(1'b0, a, 8'h00);
            chk(q, {24'h000000, e});
        end
    endtask
    // Bounded wait on seq_done (s=0) or powered (s=1)
    task wait_sig(input integer s, input logic v);
        integer n;
        begin
            n = 0;
            while ((s ? powered : seq_done) !== v) begin
                n = n + 1;
                if (n > 500) begin
                    chk(32'h0, 32'h1);
                    finish_test;
                end
                @(posedge clock);
            end
        end
    endtask
    initial begin : main
        integer o;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        rd(4'hC, 8'h00);
        rd(4'h2, 8'h00);
        $display("test reset done");
        for (o = 1; o < 4; o = o + 1) begin
            wr(4'hC, 8'h14);
            wr(4'h8, {3'b000, o[1:0], 1'b0, o[1:0]});
            chk({pos_ramp_discharge, neg_ramp_discharge, pos_switch_en},
                3'h6);
            rd(4'h8, {3'b000, o[1:0], 1'b0, o[1:0]});
            wr(4'hC, 8'h04);
            wait_sig(0, 1'b1);
            chk(ramp_current_ua, 32'h1 << o);
            $display("test order %0d done", o);
        end
        wr(4'hC, 8'h50);
        wr(4'h0, 8'h5A);
        wr(4'h4, 8'h33);
        wr(4'hC, 8'h11);
        wr(4'hC, 8'h91);
        wr(4'hC, 8'h11);
        rd(4'hC, 8'h11);
        wr(4'hC, 8'h10);
        rd(4'h0, 8'h5A);
        chk(cfg_pos_code, 32'h5A);
        rd(4'h4, 8'h00);
        chk({cfg_pos_fine, cfg_neg_code}, 32'h0);
        chk(avs_response, 32'h0);
        vpp_ok <= 1'b0;
        wr(4'hC, 8'h92);
        rd(4'hC, 8'hD2);
        wr(4'hC, 8'h50);
        rd(4'hC, 8'h10);
        vpp_ok <= 1'b1;
        $display("test programming done");
        wr(4'hC, 8'h14);
        wr(4'h8, 8'h07);
        wr(4'hC, 8'h04);
        wait_sig(0, 1'b1);
        shutdown_input_n <= 1'b0;
        repeat (3) @(posedge clock);
        chk({out_discharge_en, pos_switch_en, neg_switch_en}, 3'h4);
        wait_sig(1, 1'b0);
        chk(out_discharge_en, 32'h0);
        // Command register clears once the sequencer is back in off
        repeat (2) @(posedge clock);
        rd(4'hC, 8'h00);
        shutdown_input_n <= 1'b1;
        repeat (3 * STC) @(posedge clock);
        chk({pos_ramp_charge, neg_ramp_charge}, 32'h0);
        $display("test power-down done");
        wr(4'hC, 8'h14);
        wr(4'h8, 8'h41);
        rd(4'h8, 8'h01);
        wr(4'hC, 8'h94);
        wr(4'hC, 8'h14);
        wr(4'h8, 8'h02);
        rd(4'h8, 8'h41);
        wr(4'hC, 8'h94);
        rd(4'hC, 8'hD4);
        rd(4'h8, 8'h41);
        wr(4'hC, 8'h20);
        rd(4'hC, 8'h00);
        $display("test lockout done");
        finish_test;
    end
endmodule // drs_sequencer_tb_top

// file: verilog/drs_defines.vh
`ifndef DRS_DEFINES_VH
`define DRS_DEFINES_VH

// Register offsets (byte addresses, one word each)
`define DRS_ADDR_CFG0 4'h0
`define DRS_ADDR_CFG1 4'h4
`define DRS_ADDR_CFG2 4'h8
`define DRS_ADDR_CMD 4'hC

// Command register fields
`define DRS_CMD_OTP_GO 7
`define DRS_CMD_FAULT 6
`define DRS_CMD_RESET 5
`define DRS_CMD_SWITCHES_OFF_CMD 4
`define DRS_CMD_SEL2 2
`define DRS_CMD_SEL1 1
`define DRS_CMD_SEL0 0
`define DRS_CMD_RESET_VAL 8'h00

// Configuration byte 2 fields
`define DRS_CFG2_LOCK 6
`define DRS_CFG2_RAMP_CURRENT_SEL_HI 4
`define DRS_CFG2_RAMP_CURRENT_SEL_LO 3
`define DRS_CFG2_DISCHARGE_ON_POWERDOWN 2
`define DRS_CFG2_ORD_HI 1
`define DRS_CFG2_ORD_LO 0
`define DRS_CFG_RESET_VAL 8'h00

// Power-up orders
`define DRS_ORD_OFF 2'h0
`define DRS_ORD_NEG_FIRST 2'h1
`define DRS_ORD_POS_FIRST 2'h2
`define DRS_ORD_BOTH 2'h3

// Startup delay: 64 us at 100 MHz
`define DRS_STARTUP_US 64
`define DRS_CLK_MHZ 100
`define DRS_STARTUP_CYC (`DRS_STARTUP_US * `DRS_CLK_MHZ)

`endif

// file: verilog/drs_sequencer.v
// What this block does
// - Shutdown or switches-off holds both ramp nodes discharged.
// - Rising shutdown or clearing switches-off starts ramp charging.
// - Ramp current field selects 1, 2, 4 or 8 uA; fixed parts 1 uA.
// - Order 11 enables both ramp currents together.
// - Wait 64 us configuration delay before sequencing.
// - Order 00 off, 01 negative first, 10 positive first, 11 both.
// - Second output enabled only after first nears regulation.
// - Power-up complete only when both outputs regulate.
// - After shutdown rises, order comes from stored configuration.
// - Fixed parts behave as order 11.
// - Discharge disabled: shut down at once when shutdown falls.
// - Discharge enabled: converters off, discharge until near ground.
// - Locked part uses stored configuration only.
// - Locked part returns stored data on reads of bytes 0 to 2.
// - Programming while locked changes nothing and sets fault.
// - Lock set by programming one into stored byte 2 bit 6.
// - Reads of lock bit always show true stored lock state.
// - Programming copies live bytes to stored only where selected.
// - Setting a select bit switches that byte to live copy.
// - Selected bytes are programmed once, on the write that sets the program bit.
// - Command register is zero in shutdown once the sequencer is back in off, and at power-up.
// - Select changes take effect on configuration immediately.
// - Fault cleared by reset, power-up or writing fault clear.
// - Switches-off disables both power switches and disconnect.
`timescale 1ns/1ps
`include "drs_defines.vh"

module drs_sequencer #(
    parameter STARTUP_CYC = `DRS_STARTUP_CYC,
    parameter FIXED_VARIANT = 0
) (
    input wire clock,
    input wire nrst,
    input wire shutdown_input_n,
    input wire vpp_ok,
    input wire pos_near_reg,
    input wire neg_near_reg,
    input wire pos_discharged,
    input wire neg_discharged,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [3:0] avs_byteenable,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    output wire [1:0] avs_response,
    output reg pos_ramp_discharge,
    output reg neg_ramp_discharge,
    output reg pos_ramp_charge,
    output reg neg_ramp_charge,
    output reg [3:0] ramp_current_ua,
    output reg pos_switch_en,
    output reg neg_switch_en,
    output reg disconnect_on,
    output reg out_discharge_en,
    output reg powered,
    output reg seq_done,
    output reg [7:0] cfg_pos_code,
    output reg [7:0] cfg_neg_code,
    output reg cfg_pos_fine
);

    localparam ST_OFF = 3'h0;
    localparam ST_DELAY = 3'h1;
    localparam ST_FIRST = 3'h2;
    localparam ST_SECOND = 3'h3;
    localparam ST_DONE = 3'h4;
    localparam ST_DISCH = 3'h5;
    localparam ST_HALT = 3'h6;

    reg [7:0] live0, live1, live2;
    reg [7:0] otp0, otp1, config_byte2_stored;
    reg [7:0] cmd;
    reg fault;
    reg [2:0] state;
    reg [12:0] dly;
    reg ack;
    reg [2:0] next_state;

    wire locked = config_byte2_stored[`DRS_CFG2_LOCK];
    wire switches_off_cmd = cmd[`DRS_CMD_SWITCHES_OFF_CMD];
    // Effective selects: locked or fixed parts use stored copy
    wire sel0 = cmd[`DRS_CMD_SEL0] & ~locked & (FIXED_VARIANT == 0);
    wire sel1 = cmd[`DRS_CMD_SEL1] & ~locked & (FIXED_VARIANT == 0);
    wire sel2 = cmd[`DRS_CMD_SEL2] & ~locked & (FIXED_VARIANT == 0);
    wire [7:0] act0 = sel0 ? live0 : otp0;
    wire [7:0] act1 = sel1 ? live1 : otp1;
    wire [7:0] act2 = sel2 ? live2 : config_byte2_stored;
    wire [1:0] order = (FIXED_VARIANT != 0) ? `DRS_ORD_BOTH :
        act2[`DRS_CFG2_ORD_HI:`DRS_CFG2_ORD_LO];
    wire [1:0] ramp_current_sel = (FIXED_VARIANT != 0) ? 2'h0 :
        act2[`DRS_CFG2_RAMP_CURRENT_SEL_HI:`DRS_CFG2_RAMP_CURRENT_SEL_LO];
    wire discharge_on_powerdown = (FIXED_VARIANT != 0) ? 1'b1 : act2[`DRS_CFG2_DISCHARGE_ON_POWERDOWN];

    wire wr_cmd = avs_write & ack & (avs_address == `DRS_ADDR_CMD) &
        avs_byteenable[0];
    wire otp_go = cmd[`DRS_CMD_OTP_GO];
    // Program pulse on rising program bit
    wire prog_start = wr_cmd & avs_writedata[`DRS_CMD_OTP_GO] & ~otp_go;
    wire prog_ok = prog_start & ~locked & vpp_ok;

    // Single wait state on every access
    assign avs_waitrequest = (avs_read | avs_write) & ~ack;
    assign avs_response = 2'h0;

    always @(posedge clock or negedge nrst) begin
        if (!nrst)
            ack <= 1'b0;
        else
            ack <= (avs_read | avs_write) & ~ack;
    end

    // Register writes
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            live0 <= `DRS_CFG_RESET_VAL;
            live1 <= `DRS_CFG_RESET_VAL;
            live2 <= `DRS_CFG_RESET_VAL;
            otp0 <= `DRS_CFG_RESET_VAL;
            otp1 <= `DRS_CFG_RESET_VAL;
            config_byte2_stored <= `DRS_CFG_RESET_VAL;
            cmd <= `DRS_CMD_RESET_VAL;
            fault <= 1'b0;
        end else if (!shutdown_input_n && state == ST_OFF) begin
            cmd <= `DRS_CMD_RESET_VAL;
            fault <= 1'b0;
        end else begin
            if (avs_write && ack && avs_byteenable[0]) begin
                case (avs_address)
                    `DRS_ADDR_CFG0: live0 <= avs_writedata[7:0];
                    `DRS_ADDR_CFG1: live1 <= avs_writedata[7:0];
                    `DRS_ADDR_CFG2: live2 <= avs_writedata[7:0] & 8'h7F;
                    default: ;
                endcase
            end
            if (wr_cmd) begin
                if (avs_writedata[`DRS_CMD_RESET])
                    cmd <= `DRS_CMD_RESET_VAL;
                else
                    cmd <= avs_writedata[7:0] & 8'hB7;
            end
            // One-time bits only ever go from zero to one
            if (prog_ok) begin
                if (cmd[`DRS_CMD_SEL0] || avs_writedata[`DRS_CMD_SEL0])
                    otp0 <= otp0 | live0;
                if (cmd[`DRS_CMD_SEL1] || avs_writedata[`DRS_CMD_SEL1])
                    otp1 <= otp1 | live1;
                if (cmd[`DRS_CMD_SEL2] || avs_writedata[`DRS_CMD_SEL2])
                    config_byte2_stored <= config_byte2_stored | (live2 & 8'h7F);
            end
            // Set wins over clear
            if (prog_start && (locked || !vpp_ok))
                fault <= 1'b1;
            else if (wr_cmd && avs_writedata[`DRS_CMD_FAULT])
                fault <= 1'b0;
            else if (wr_cmd && avs_writedata[`DRS_CMD_RESET])
                fault <= 1'b0;
        end
    end

    // Read data
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            avs_readdata <= 32'h0;
        end else if (avs_read && !ack) begin
            case (avs_address)
                `DRS_ADDR_CFG0: avs_readdata <= {24'h0, act0};
                `DRS_ADDR_CFG1: avs_readdata <= {24'h0, act1};
                `DRS_ADDR_CFG2: avs_readdata <= {24'h0, act2[7],
                    locked, act2[5:0]};
                `DRS_ADDR_CMD: avs_readdata <= {24'h0, cmd[7], fault,
                    cmd[5:0]};
                default: avs_readdata <= 32'h0;
            endcase
        end
    end

    // Sequencer
    always @* begin
        next_state = state;
        case (state)
            ST_OFF:
                if (shutdown_input_n && !switches_off_cmd)
                    next_state = ST_DELAY;
            ST_DELAY:
                if (dly == 13'h0000 && order != `DRS_ORD_OFF)
                    next_state = ST_FIRST;
            ST_FIRST:
                if (order == `DRS_ORD_BOTH)
                    next_state = ST_SECOND;
                else if ((order == `DRS_ORD_NEG_FIRST && neg_near_reg) ||
                    (order == `DRS_ORD_POS_FIRST && pos_near_reg))
                    next_state = ST_SECOND;
            ST_SECOND:
                if (pos_near_reg && neg_near_reg)
                    next_state = ST_DONE;
            ST_DONE:
                next_state = ST_DONE;
            ST_DISCH:
                if (pos_discharged && neg_discharged)
                    next_state = ST_HALT;
            ST_HALT:
                next_state = ST_OFF;
            default:
                next_state = ST_OFF;
        endcase
        if (state != ST_OFF && state != ST_DISCH && state != ST_HALT) begin
            if (!shutdown_input_n)
                next_state = discharge_on_powerdown ? ST_DISCH : ST_OFF;
            else if (switches_off_cmd)
                next_state = ST_OFF;
        end
    end

    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state <= ST_OFF;
            dly <= 13'h0000;
        end else begin
            state <= next_state;
            if (state == ST_OFF)
                dly <= STARTUP_CYC[12:0] - 13'h0001;
            else if (state == ST_DELAY && dly != 13'h0000)
                dly <= dly - 13'h0001;
        end
    end

    // Outputs
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pos_ramp_discharge <= 1'b1;
            neg_ramp_discharge <= 1'b1;
            pos_ramp_charge <= 1'b0;
            neg_ramp_charge <= 1'b0;
            ramp_current_ua <= 4'h1;
            pos_switch_en <= 1'b0;
            neg_switch_en <= 1'b0;
            disconnect_on <= 1'b0;
            out_discharge_en <= 1'b0;
            powered <= 1'b0;
            seq_done <= 1'b0;
            cfg_pos_code <= 8'h00;
            cfg_neg_code <= 8'h00;
            cfg_pos_fine <= 1'b0;
        end else begin
            ramp_current_ua <= 4'h1 << ramp_current_sel;
            cfg_pos_code <= act0;
            cfg_neg_code <= act1;
            cfg_pos_fine <= act2[5];
            // Ramps held low unless actively sequencing
            pos_ramp_discharge <= ~(next_state == ST_FIRST ||
                next_state == ST_SECOND || next_state == ST_DONE);
            neg_ramp_discharge <= ~(next_state == ST_FIRST ||
                next_state == ST_SECOND || next_state == ST_DONE);
            pos_ramp_charge <= (next_state == ST_FIRST &&
                order != `DRS_ORD_NEG_FIRST) ||
                next_state == ST_SECOND || next_state == ST_DONE;
            neg_ramp_charge <= (next_state == ST_FIRST &&
                order != `DRS_ORD_POS_FIRST) ||
                next_state == ST_SECOND || next_state == ST_DONE;
            pos_switch_en <= (next_state == ST_FIRST &&
                order != `DRS_ORD_NEG_FIRST) ||
                next_state == ST_SECOND || next_state == ST_DONE;
            neg_switch_en <= (next_state == ST_FIRST &&
                order != `DRS_ORD_POS_FIRST) ||
                next_state == ST_SECOND || next_state == ST_DONE;
            disconnect_on <= (next_state == ST_FIRST &&
                order != `DRS_ORD_NEG_FIRST) ||
                next_state == ST_SECOND || next_state == ST_DONE;
            out_discharge_en <= next_state == ST_DISCH;
            powered <= next_state != ST_OFF && next_state != ST_HALT;
            seq_done <= next_state == ST_DONE;
        end
    end

endmodule // drs_sequencer
